// ### hdl/ptss_pkg.sv
package ptss_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] PTSS_OFS_FIXED = 8'h5c;
    localparam logic [7:0] PTSS_OFS_CTRL = 8'h5d;
    localparam logic [7:0] PTSS_OFS_EDGE = 8'h5e;
    localparam logic [7:0] PTSS_OFS_RSVD_LO = 8'h5f;
    localparam logic [7:0] PTSS_OFS_RSVD_HI = 8'h68;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int PTSS_TEST_LSB = 0;
    localparam int PTSS_SRC_LSB = 2;
    localparam int PTSS_INC_LSB = 4;
    localparam int PTSS_EDGE_BIT = 0;
    localparam int PTSS_OBS_BIT = 1;
    localparam int PTSS_ID_LSB = 5;
    localparam int PTSS_RAW_SPLIT = 7;
    localparam logic [7:0] PTSS_FIXED_RST = 8'h00;
    localparam logic [7:0] PTSS_CTRL_RST = 8'h00;
    localparam logic [1:0] PTSS_EDGE_RST = 2'h0;
    // Arbitrary identity value shown in the top bits of the edge register.
    localparam logic [2:0] PTSS_ID_CODE = 3'h5;

    // ------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PTSS_TEST_NORMAL = 2'b00,
        PTSS_TEST_BYP_FE = 2'b01,
        PTSS_TEST_RAW_MSB = 2'b10,
        PTSS_TEST_RAW_LSB = 2'b11
    } ptss_test_t;

    typedef enum logic [1:0] {
        PTSS_SRC_ADC = 2'b00,
        PTSS_SRC_FIXED = 2'b01,
        PTSS_SRC_CNT_SCAN = 2'b10,
        PTSS_SRC_CNT_LINE = 2'b11
    } ptss_src_t;

    typedef enum logic [1:0] {
        PTSS_INC_1 = 2'b00,
        PTSS_INC_4 = 2'b01,
        PTSS_INC_16 = 2'b10,
        PTSS_INC_NONE = 2'b11
    } ptss_inc_t;

    localparam logic [15:0] PTSS_STEP_1 = 16'h0001;
    localparam logic [15:0] PTSS_STEP_4 = 16'h0004;
    localparam logic [15:0] PTSS_STEP_16 = 16'h0010;
    localparam logic [15:0] PTSS_STEP_NONE = 16'h0000;

endpackage

// ### hdl/ptss_top.sv
// Design decision made here: strobed register access.
`timescale 1ns/1ns

// Overview of operation
// - Front-end bypass mode routes sensor past the front end, converter correction kept.
// - Raw MSB mode bypasses front end and correction, outputs uncorrected upper half.
// - Raw LSB mode bypasses front end and correction, outputs uncorrected lower half.
// - Source field picks converter output, fixed register word, or test counter.
// - Per-scan counter source clears the counter at each scan start.
// - Per-line counter source clears the counter at each line start.
// - Cleared counter holds zero and advances once per data pixel.
// - Increment field sets step 1, 4 or 16; fourth code gives no step.
// - One bit picks sampling edge; software keeps it at zero.
// - Observe bit drives the correction strobe onto the second lamp output.
module ptss_top (
    // Clock and reset
    input logic CLK_SYS,
    input logic RST,
    // Register port
    input logic [7:0] REG_ADDR,
    input logic [7:0] REG_WDATA,
    input logic REG_WR,
    input logic REG_RD,
    output logic [7:0] REG_RDATA,
    // Converter data and scan timing
    input logic [15:0] ADC_WORD,
    input logic [13:0] ADC_RAW,
    input logic PIX_VALID,
    input logic SCAN_START,
    input logic LINE_START,
    // Pixel processing feed
    output logic [15:0] PIX_DATA,
    output logic PIX_STB,
    // Front end controls
    output logic ANALOG_FRONT_END_BYPASS,
    output logic ADC_CORR_BYPASS,
    output logic SAMPLE_EDGE_FALL,
    // Lamp pin
    input logic CORR_STROBE_IN,
    input logic LAMP2_NORMAL_IN,
    output logic SECOND_LAMP_OUT
);
    import ptss_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] fixed_reg;
    logic [7:0] ctrl_reg;
    logic [1:0] edge_reg;
    logic [7:0] rdata_reg;
    logic [15:0] counter_reg;
    logic [15:0] pix_data_reg;
    logic pix_stb_reg;
    logic fe_byp_reg;
    logic corr_byp_reg;
    logic edge_out_reg;
    logic lamp_reg;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    wire wr_fixed = REG_WR && (REG_ADDR == PTSS_OFS_FIXED);
    wire wr_ctrl = REG_WR && (REG_ADDR == PTSS_OFS_CTRL);
    wire wr_edge = REG_WR && (REG_ADDR == PTSS_OFS_EDGE);
    wire wdata_edge_bit = REG_WDATA[PTSS_EDGE_BIT];
    wire rsvd_hit = (REG_ADDR >= PTSS_OFS_RSVD_LO) && (REG_ADDR <= PTSS_OFS_RSVD_HI);

    wire ptss_test_t test_mode = ptss_test_t'(ctrl_reg[PTSS_TEST_LSB +: 2]);
    wire ptss_src_t src_sel = ptss_src_t'(ctrl_reg[PTSS_SRC_LSB +: 2]);
    wire ptss_inc_t inc_sel = ptss_inc_t'(ctrl_reg[PTSS_INC_LSB +: 2]);
    wire obs_on = edge_reg[PTSS_OBS_BIT];

    logic [7:0] rd_mux;
    always_comb begin
        if (REG_ADDR == PTSS_OFS_FIXED) begin
            rd_mux = fixed_reg;
        end else if (REG_ADDR == PTSS_OFS_CTRL) begin
            rd_mux = ctrl_reg;
        end else if (REG_ADDR == PTSS_OFS_EDGE) begin
            rd_mux = {PTSS_ID_CODE, 3'h0, edge_reg};
        end else if (rsvd_hit) begin
            rd_mux = 8'h00;
        end else begin
            rd_mux = 8'h00;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            fixed_reg <= PTSS_FIXED_RST;
            ctrl_reg <= PTSS_CTRL_RST;
            edge_reg <= PTSS_EDGE_RST;
        end else begin
            if (wr_fixed) begin
                fixed_reg <= REG_WDATA;
            end
            if (wr_ctrl) begin
                ctrl_reg <= REG_WDATA;
            end
            if (wr_edge) begin
                edge_reg <= REG_WDATA[1:0];
            end
        end
    end

    // Read data stands only in the cycle after the read strobe.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= REG_RD ? rd_mux : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Test counter
    // ------------------------------------------------------------
    function automatic logic [15:0] step_of(input ptss_inc_t sel);
        case (sel)
            PTSS_INC_1: step_of = PTSS_STEP_1;
            PTSS_INC_4: step_of = PTSS_STEP_4;
            PTSS_INC_16: step_of = PTSS_STEP_16;
            default: step_of = PTSS_STEP_NONE;
        endcase
    endfunction

    wire [15:0] step = step_of(inc_sel);
    wire cnt_src = (src_sel == PTSS_SRC_CNT_SCAN) || (src_sel == PTSS_SRC_CNT_LINE);
    wire clr_scan = (src_sel == PTSS_SRC_CNT_SCAN) && SCAN_START;
    wire clr_line = (src_sel == PTSS_SRC_CNT_LINE) && LINE_START;
    wire cnt_clr = clr_scan || clr_line;
    wire [15:0] cnt_cur = cnt_clr ? 16'h0000 : counter_reg;
    wire [15:0] cnt_sum = cnt_cur + step;
    wire [15:0] counter_next = (PIX_VALID && cnt_src) ? cnt_sum : cnt_cur;

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            counter_reg <= 16'h0000;
        end else begin
            counter_reg <= counter_next;
        end
    end

    // ------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------
    wire [15:0] raw_msb_word = {ADC_RAW[13:PTSS_RAW_SPLIT], 9'h000};
    wire [15:0] raw_lsb_word = {ADC_RAW[PTSS_RAW_SPLIT-1:0], 9'h000};
    wire [15:0] fixed_word = {fixed_reg, ctrl_reg};
    wire [15:0] adc_sel_word = (test_mode == PTSS_TEST_RAW_MSB) ? raw_msb_word :
                               (test_mode == PTSS_TEST_RAW_LSB) ? raw_lsb_word : ADC_WORD;
    wire [15:0] pix_data_next = (src_sel == PTSS_SRC_ADC) ? adc_sel_word :
                                (src_sel == PTSS_SRC_FIXED) ? fixed_word : cnt_cur;

    // Each pixel slot yields one word one cycle later; line timing is unchanged.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            pix_data_reg <= 16'h0000;
            pix_stb_reg <= 1'b0;
        end else begin
            pix_stb_reg <= PIX_VALID;
            if (PIX_VALID) begin
                pix_data_reg <= pix_data_next;
            end
        end
    end

    // ------------------------------------------------------------
    // Front end and lamp pin
    // ------------------------------------------------------------
    wire fe_byp_next = (test_mode != PTSS_TEST_NORMAL);
    wire corr_byp_next = (test_mode == PTSS_TEST_RAW_MSB) || (test_mode == PTSS_TEST_RAW_LSB);
    wire lamp_next = obs_on ? CORR_STROBE_IN : LAMP2_NORMAL_IN;

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            fe_byp_reg <= 1'b0;
            corr_byp_reg <= 1'b0;
            edge_out_reg <= 1'b0;
            lamp_reg <= 1'b0;
        end else begin
            fe_byp_reg <= fe_byp_next;
            corr_byp_reg <= corr_byp_next;
            edge_out_reg <= edge_reg[PTSS_EDGE_BIT];
            lamp_reg <= lamp_next;
        end
    end

    assign REG_RDATA = rdata_reg;
    assign PIX_DATA = pix_data_reg;
    assign PIX_STB = pix_stb_reg;
    assign ANALOG_FRONT_END_BYPASS = fe_byp_reg;
    assign ADC_CORR_BYPASS = corr_byp_reg;
    assign SAMPLE_EDGE_FALL = edge_out_reg;
    assign SECOND_LAMP_OUT = lamp_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    a_fe_bypass_keep: assert property (
        (test_mode == PTSS_TEST_BYP_FE) |=> (ANALOG_FRONT_END_BYPASS && !ADC_CORR_BYPASS))
        else $error("front end bypass mode drives wrong controls");

    a_raw_msb_out: assert property (
        (PIX_VALID && src_sel == PTSS_SRC_ADC && test_mode == PTSS_TEST_RAW_MSB)
        |=> (PIX_DATA == $past(raw_msb_word)) && ADC_CORR_BYPASS)
        else $error("raw upper half not presented");

    a_raw_lsb_out: assert property (
        (PIX_VALID && src_sel == PTSS_SRC_ADC && test_mode == PTSS_TEST_RAW_LSB)
        |=> (PIX_DATA == $past(raw_lsb_word)) && ANALOG_FRONT_END_BYPASS)
        else $error("raw lower half not presented");

    a_fixed_src: assert property (
        (PIX_VALID && src_sel == PTSS_SRC_FIXED) |=> (PIX_DATA == $past(fixed_word)))
        else $error("fixed source word wrong");

    a_scan_clear: assert property (
        (clr_scan && !PIX_VALID) |=> (counter_reg == 16'h0000))
        else $error("counter not cleared at scan start");

    a_line_clear: assert property (
        (clr_line && PIX_VALID && inc_sel == PTSS_INC_4) |=> (counter_reg == 16'h0004))
        else $error("counter not restarted at line start");

    a_cnt_advance: assert property (
        (PIX_VALID && cnt_src && !cnt_clr) |=> (counter_reg == $past(cnt_sum)))
        else $error("counter did not advance by its step");

    a_cnt_hold: assert property (
        (!PIX_VALID && !cnt_clr) |=> $stable(counter_reg))
        else $error("counter moved without a pixel");

    a_step_sixteen: assert property (
        (PIX_VALID && src_sel == PTSS_SRC_CNT_SCAN && inc_sel == PTSS_INC_16 && !cnt_clr)
        |=> (PIX_DATA == $past(counter_reg)) && (counter_reg == $past(counter_reg) + 16'h0010))
        else $error("step of sixteen not applied");

    a_edge_follow: assert property (
        wr_edge |-> ##2 (SAMPLE_EDGE_FALL == $past(wdata_edge_bit, 2)))
        else $error("sampling edge select not applied");

    a_lamp_route: assert property (
        obs_on |=> (SECOND_LAMP_OUT == $past(CORR_STROBE_IN)))
        else $error("strobe not routed to lamp pin");

    a_lamp_normal: assert property (
        !obs_on |=> (SECOND_LAMP_OUT == $past(LAMP2_NORMAL_IN)))
        else $error("lamp pin lost its normal function");

    a_pix_slot: assert property (
        PIX_STB == $past(PIX_VALID))
        else $error("pixel word not delivered in its slot");

    a_read_ctrl: assert property (
        (REG_RD && REG_ADDR == PTSS_OFS_CTRL) |=> (REG_RDATA == $past(ctrl_reg)))
        else $error("control register read back wrong");

    a_read_fixed: assert property (
        (REG_RD && REG_ADDR == PTSS_OFS_FIXED) |=> (REG_RDATA == $past(fixed_reg)))
        else $error("fixed register read back wrong");

    a_read_rsvd: assert property (
        (REG_RD && rsvd_hit) |=> (REG_RDATA == 8'h00))
        else $error("reserved register read not zero");

    a_read_idle: assert property (
        !REG_RD |=> (REG_RDATA == 8'h00))
        else $error("read data stood outside its cycle");

    a_normal_ctrl: assert property (
        (test_mode == PTSS_TEST_NORMAL) |=> (!ANALOG_FRONT_END_BYPASS && !ADC_CORR_BYPASS))
        else $error("bypass controls active in normal mode");

    a_adc_pass: assert property (
        (PIX_VALID && src_sel == PTSS_SRC_ADC && (test_mode == PTSS_TEST_NORMAL || test_mode == PTSS_TEST_BYP_FE))
        |=> (PIX_DATA == $past(ADC_WORD)))
        else $error("converter word not passed through");

    a_scan_first_zero: assert property (
        (PIX_VALID && clr_scan) |=> (PIX_DATA == 16'h0000))
        else $error("first pixel after scan start not zero");

    a_step_one: assert property (
        (PIX_VALID && cnt_src && !cnt_clr && inc_sel == PTSS_INC_1)
        |=> (counter_reg == $past(counter_reg) + 16'h0001))
        else $error("step of one not applied");

    a_pix_hold: assert property (
        !PIX_VALID |=> $stable(PIX_DATA))
        else $error("pixel word changed outside a slot");

    c_line_restart: cover property (
        clr_line && PIX_VALID);

    c_scan_count: cover property (
        clr_scan ##1 PIX_VALID [*3]);

    c_fixed_pixel: cover property (
        PIX_VALID && src_sel == PTSS_SRC_FIXED);

    c_lamp_observe: cover property (
        obs_on && CORR_STROBE_IN ##1 SECOND_LAMP_OUT);

    c_raw_msb: cover property (
        PIX_VALID && test_mode == PTSS_TEST_RAW_MSB && src_sel == PTSS_SRC_ADC);

endmodule

// ### verif/testbench.sv
`timescale 1ns/1ns

module testbench;
    import ptss_pkg::*;

    logic CLK_SYS, RST, REG_WR, REG_RD, PIX_VALID, SCAN_START, LINE_START, PIX_STB;
    logic ANALOG_FRONT_END_BYPASS, ADC_CORR_BYPASS, SAMPLE_EDGE_FALL;
    logic CORR_STROBE_IN, LAMP2_NORMAL_IN, SECOND_LAMP_OUT;
    logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, ctrl, fix;
    logic [15:0] ADC_WORD, PIX_DATA, cnt;
    logic [13:0] ADC_RAW;
    int n_errors = 0;
    int total_checks = 0;

    ptss_top i_dut (.CLK_SYS(CLK_SYS), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .ADC_WORD(ADC_WORD),
        .ADC_RAW(ADC_RAW), .PIX_VALID(PIX_VALID), .SCAN_START(SCAN_START), .LINE_START(LINE_START),
        .PIX_DATA(PIX_DATA), .PIX_STB(PIX_STB), .ANALOG_FRONT_END_BYPASS(ANALOG_FRONT_END_BYPASS),
        .ADC_CORR_BYPASS(ADC_CORR_BYPASS), .SAMPLE_EDGE_FALL(SAMPLE_EDGE_FALL),
        .CORR_STROBE_IN(CORR_STROBE_IN), .LAMP2_NORMAL_IN(LAMP2_NORMAL_IN), .SECOND_LAMP_OUT(SECOND_LAMP_OUT));

    // ------------------------------------------------------------
    // Checking and expectations
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    function automatic logic [15:0] step_of(input logic [1:0] inc);
        case (inc)
            2'h0: step_of = 16'h0001;
            2'h1: step_of = 16'h0004;
            2'h2: step_of = 16'h0010;
            default: step_of = 16'h0000;
        endcase
    endfunction

    function automatic logic [15:0] exp_pix(input logic [15:0] w, input logic [13:0] r);
        case (ctrl[3:2])
            2'h0: exp_pix = (ctrl[1:0] == 2'h2) ? {r[13:7], 9'h000} :
                            (ctrl[1:0] == 2'h3) ? {r[6:0], 9'h000} : w;
            2'h1: exp_pix = {fix, ctrl};
            default: exp_pix = cnt;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Register port and pixel stream drivers
    // ------------------------------------------------------------
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK_SYS);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'h1;
        @(posedge CLK_SYS);
        REG_WR <= 1'h0;
        if (a == PTSS_OFS_CTRL) ctrl = d;
        if (a == PTSS_OFS_FIXED) fix = d;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge CLK_SYS);
        REG_ADDR <= a;
        REG_RD <= 1'h1;
        @(posedge CLK_SYS);
        REG_RD <= 1'h0;
        @(negedge CLK_SYS);
        check("reg_rdata", {8'h00, REG_RDATA}, {8'h00, exp});
    endtask

    task automatic set_ctrl(input logic [7:0] d);
        reg_wr(PTSS_OFS_CTRL, d);
        @(posedge CLK_SYS);
        @(negedge CLK_SYS);
        check("fe_bypass", {15'h0000, ANALOG_FRONT_END_BYPASS}, {15'h0000, d[1:0] != 2'h0});
        check("corr_bypass", {15'h0000, ADC_CORR_BYPASS}, {15'h0000, d[1]});
    endtask

    // Drives a start pulse with no pixel beside it.
    task automatic start_pulse(input logic s, input logic l);
        @(posedge CLK_SYS);
        SCAN_START <= s;
        LINE_START <= l;
        if ((s && ctrl[3:2] == 2'h2) || (l && ctrl[3:2] == 2'h3)) cnt = 16'h0000;
        @(posedge CLK_SYS);
        SCAN_START <= 1'h0;
        LINE_START <= 1'h0;
    endtask

    // Sends n back-to-back pixels, the first one beside the chosen start pulses.
    task automatic burst(input int n, input logic s, input logic l);
        logic [15:0] e, e_next, w;
        logic [13:0] r;
        e = 16'h0000;
        for (int i = 0; i <= n; i++) begin
            @(posedge CLK_SYS);
            if (i < n) begin
                w = 16'($urandom);
                r = 14'($urandom);
                ADC_WORD <= w;
                ADC_RAW <= r;
                PIX_VALID <= 1'h1;
                SCAN_START <= s && i == 0;
                LINE_START <= l && i == 0;
                if (i == 0 && ((s && ctrl[3:2] == 2'h2) || (l && ctrl[3:2] == 2'h3))) cnt = 16'h0000;
                e_next = exp_pix(w, r);
                if (ctrl[3]) cnt = cnt + step_of(ctrl[5:4]);
            end else begin
                PIX_VALID <= 1'h0;
                SCAN_START <= 1'h0;
                LINE_START <= 1'h0;
            end
            @(negedge CLK_SYS);
            if (i > 0) begin
                check("pix_stb", {15'h0000, PIX_STB}, 16'h0001);
                check("pix_data", PIX_DATA, e);
            end
            e = e_next;
        end
        @(negedge CLK_SYS);
        check("pix_stb_idle", {15'h0000, PIX_STB}, 16'h0000);
        check("pix_data_hold", PIX_DATA, e);
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        CLK_SYS = 1'h0;
        forever #10 CLK_SYS = ~CLK_SYS;
    end

    initial begin
        #2000000;
        n_errors++;
        final_report();
    end

    initial begin
        logic lamp_src;
        RST = 1'h1;
        {REG_WR, REG_RD, PIX_VALID, SCAN_START, LINE_START, CORR_STROBE_IN, LAMP2_NORMAL_IN} = 7'h00;
        REG_ADDR = 8'h00;
        REG_WDATA = 8'h00;
        ADC_WORD = 16'h0000;
        ADC_RAW = 14'h0000;
        ctrl = 8'h00;
        fix = 8'h00;
        cnt = 16'h0000;
        void'($urandom(32'hfa46));
        repeat (10) @(posedge CLK_SYS);
        RST <= 1'h0;
        reg_rd(PTSS_OFS_FIXED, PTSS_FIXED_RST);
        reg_rd(PTSS_OFS_CTRL, PTSS_CTRL_RST);
        reg_rd(PTSS_OFS_EDGE, {PTSS_ID_CODE, 5'h00});
        for (int a = 8'h5f; a <= 8'h68; a++) reg_wr(8'(a), 8'h00);
        reg_wr(8'h10, 8'hff);
        reg_rd(8'h60, 8'h00);
        reg_rd(8'h10, 8'h00);
        for (int t = 0; t < 4; t++) begin
            set_ctrl({6'h00, 2'(t)});
            burst(3, 1'h0, 1'h0);
        end
        reg_wr(PTSS_OFS_FIXED, 8'($urandom));
        set_ctrl({2'($urandom), 4'h4, 2'($urandom)});
        reg_rd(PTSS_OFS_CTRL, ctrl);
        reg_rd(PTSS_OFS_FIXED, fix);
        burst(2, 1'h0, 1'h0);
        for (int k = 0; k < 4; k++) begin
            set_ctrl({2'h0, 2'(k), 4'h8});
            burst(5, 1'h1, 1'h0);
            burst(3, 1'h0, 1'h1);
            start_pulse(1'h1, 1'h0);
            burst(2, 1'h0, 1'h0);
            set_ctrl({2'h0, 2'(k), 4'hc});
            burst(4, 1'h0, 1'h1);
            burst(3, 1'h1, 1'h0);
            start_pulse(1'h0, 1'h1);
            burst(2, 1'h0, 1'h0);
        end
        for (int k = 0; k < 12; k++) begin
            set_ctrl(8'($urandom));
            burst(1 + ($urandom % 6), 1'($urandom), 1'($urandom));
        end
        for (int m = 0; m < 4; m++) begin
            reg_wr(PTSS_OFS_EDGE, {6'h00, 2'(m)});
            reg_rd(PTSS_OFS_EDGE, {PTSS_ID_CODE, 3'h0, 2'(m)});
            @(negedge CLK_SYS);
            check("edge_fall", {15'h0000, SAMPLE_EDGE_FALL}, {15'h0000, m[0]});
            for (int c = 0; c < 8; c++) begin
                @(posedge CLK_SYS);
                CORR_STROBE_IN <= 1'($urandom);
                LAMP2_NORMAL_IN <= 1'($urandom);
                @(negedge CLK_SYS);
                lamp_src = m[1] ? CORR_STROBE_IN : LAMP2_NORMAL_IN;
                @(negedge CLK_SYS);
                check("second_lamp", {15'h0000, SECOND_LAMP_OUT}, {15'h0000, lamp_src});
            end
        end
        reg_wr(PTSS_OFS_EDGE, 8'h00);
        final_report();
    end
endmodule
